//--- verilog/ctt_timing.sv
// Responder transaction timing engine with AXI4-Lite registers
// Function
// - Each transaction: request in, acknowledge out after ack delay, then window
// - Okay read sends read data the read data delay after request end
// - Read data delay is ack delay plus a common read gap
// - One write data delay used regardless of channel position
// - Okay write ends at later of window end and data end
// - Nack or nonexistent write takes no data, ends at later of window end and data stop
// - Serial address packet spans four cycles per extra octbyte
// - Full length is length value plus one octbyte
// - Nack every hit request during retry interval, then accept with Okay
`include "ctt_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module ctt_timing #(
  parameter int DW    = 64,
  parameter int DEPTH = 8
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          req_valid,
  input  wire logic          req_write,
  input  wire logic          req_hit,
  input  wire logic          req_miss,
  input  wire logic [4:0]    req_length_value,
  input  wire logic [7:0]    req_column,
  input  wire logic          saddr_valid,
  input  wire logic [7:0]    serial_column_address,
  input  wire logic          sctrl_valid,
  input  wire logic          wr_in_valid,
  input  wire logic [DW-1:0] wr_in_data,
  output logic               ack_valid,
  output logic [1:0]         ack_code,
  output logic               rd_valid,
  output logic [DW-1:0]      rd_data,
  input  wire logic          core_rd_valid,
  output logic               core_rd_ready,
  input  wire logic [DW-1:0] core_rd_data,
  output logic               core_wr_valid,
  output logic [DW-1:0]      core_wr_data,
  output logic               col_valid,
  output logic [7:0]         col_addr,
  output logic               txn_done
);
  function automatic logic due(input logic [7:0] c, input logic [4:0] d);
    due = c == ({3'h0, d} - 8'h01);
  endfunction

  // Register file
  logic        en_reg, en_next;
  logic [15:0] dly_reg, dly_next, retry_reg, retry_next;
  logic [15:0] tcnt_reg, tcnt_next;
  logic        bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        wr_go, rd_go;
  logic [4:0]  ack_dly, win_len, rd_dly, wr_dly, win_end;

  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
  assign rd_go = s_axi_arvalid & ~rvalid_reg;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  assign ack_dly = {1'b0, dly_reg[`CTT_DLY_ACK_LSB +: 4]};
  assign win_len = {1'b0, dly_reg[`CTT_DLY_WIN_LSB +: 4]};
  assign rd_dly  = ack_dly + {1'b0, dly_reg[`CTT_DLY_GAP_LSB +: 4]};
  assign wr_dly  = {1'b0, dly_reg[`CTT_DLY_WR_LSB +: 4]};
  assign win_end = ack_dly + win_len;

  // Transaction state
  ctt_pkg::ctt_state_t state_reg, state_next;
  ctt_pkg::ctt_ack_t   code_reg, code_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic        wr_reg, wr_next, act_reg, act_next;
  logic        ddone_reg, ddone_next, term_reg, term_next;
  logic [4:0]  len_reg, len_next, oct_reg, oct_next;
  logic [1:0]  sub_reg, sub_next;
  logic [15:0] rty_reg, rty_next;
  logic        accept, in_win, dstart, last_oct, slot, win_over, finish;
  logic        fifo_valid;
  logic [DW-1:0] fifo_data;

  // Outputs
  logic          ackv_reg, ackv_next, rdv_reg, rdv_next;
  logic [1:0]    ackc_reg, ackc_next;
  logic [DW-1:0] rdd_reg, rdd_next, cwd_reg, cwd_next;
  logic          cwv_reg, cwv_next, colv_reg, colv_next, done_reg, done_next;
  logic [7:0]    cola_reg, cola_next;

  always_comb begin
    en_next     = en_reg;
    dly_next    = dly_reg;
    retry_next  = retry_reg;
    bvalid_next = bvalid_reg & ~s_axi_bready;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg & ~s_axi_rready;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    tcnt_next   = finish ? tcnt_reg + 16'h0001 : tcnt_reg;
    if (wr_go) begin
      bvalid_next = 1'b1;
      bresp_next  = `CTT_RESP_OKAY;
      case (s_axi_awaddr)
        `CTT_OFF_CTRL: begin
          if (s_axi_wstrb[0]) begin
            en_next = s_axi_wdata[`CTT_CTRL_EN];
          end
        end
        `CTT_OFF_DELAY: begin
          if (s_axi_wstrb[0]) begin
            dly_next[7:0] = s_axi_wdata[7:0];
          end
          if (s_axi_wstrb[1]) begin
            dly_next[15:8] = s_axi_wdata[15:8];
          end
        end
        `CTT_OFF_RETRY: begin
          if (s_axi_wstrb[0]) begin
            retry_next[7:0] = s_axi_wdata[7:0];
          end
          if (s_axi_wstrb[1]) begin
            retry_next[15:8] = s_axi_wdata[15:8];
          end
        end
        `CTT_OFF_STATUS, `CTT_OFF_COUNT: begin
        end
        default: bresp_next = `CTT_RESP_SLVERR;
      endcase
    end
    if (rd_go) begin
      rvalid_next = 1'b1;
      rresp_next  = `CTT_RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      case (s_axi_araddr)
        `CTT_OFF_CTRL:   rdata_next[0] = en_reg;
        `CTT_OFF_DELAY:  rdata_next[15:0] = dly_reg;
        `CTT_OFF_RETRY:  rdata_next[15:0] = retry_reg;
        `CTT_OFF_STATUS: begin
          rdata_next[1:0] = state_reg;
          rdata_next[2] = act_reg;
          rdata_next[`CTT_ST_BUSY] = rty_reg != 16'h0000;
          rdata_next[`CTT_ST_CODE_LSB +: 2] = code_reg;
        end
        `CTT_OFF_COUNT:  rdata_next[15:0] = tcnt_reg;
        default: rresp_next = `CTT_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_reg     <= `CTT_RST_CTRL;
      dly_reg    <= `CTT_RST_DELAY;
      retry_reg  <= `CTT_RST_RETRY;
      tcnt_reg   <= 16'h0000;
      bvalid_reg <= 1'b0;
      bresp_reg  <= 2'h0;
      rvalid_reg <= 1'b0;
      rresp_reg  <= 2'h0;
      rdata_reg  <= 32'h0000_0000;
    end else begin
      en_reg     <= en_next;
      dly_reg    <= dly_next;
      retry_reg  <= retry_next;
      tcnt_reg   <= tcnt_next;
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
    end
  end

  assign accept   = (state_reg == ctt_pkg::CTT_ST_IDLE) & req_valid & en_reg;
  assign in_win   = cnt_reg >= {3'h0, ack_dly} &&
                    cnt_reg < {3'h0, win_end};
  assign win_over = cnt_reg >= {3'h0, win_end};
  assign dstart   = (state_reg == ctt_pkg::CTT_ST_XFER) &&
                    code_reg == ctt_pkg::CTT_ACK_OKAY && !act_reg &&
                    !ddone_reg && due(cnt_reg, wr_reg ? wr_dly : rd_dly);
  assign last_oct = oct_reg == len_reg || term_reg;
  assign slot     = dstart | (act_reg & sub_reg == `CTT_OCT_CYCLES & ~last_oct);
  assign finish   = (state_reg == ctt_pkg::CTT_ST_XFER) && win_over &&
                    (code_reg == ctt_pkg::CTT_ACK_OKAY ? ddone_reg
                     : (!wr_reg || (!wr_in_valid &&
                        cnt_reg > {3'h0, wr_dly})));

  always_comb begin
    state_next = state_reg;
    code_next  = code_reg;
    cnt_next   = cnt_reg == `CTT_CNT_MAX ? cnt_reg : cnt_reg + 8'h01;
    wr_next    = wr_reg;
    len_next   = len_reg;
    act_next   = act_reg;
    ddone_next = ddone_reg;
    term_next  = term_reg;
    oct_next   = oct_reg;
    sub_next   = act_reg ? sub_reg + 2'h1 : sub_reg;
    rty_next   = rty_reg != 16'h0000 ? rty_reg - 16'h0001 : rty_reg;
    case (state_reg)
      ctt_pkg::CTT_ST_IDLE: begin
        if (accept) begin
          state_next = ctt_pkg::CTT_ST_XFER;
          cnt_next   = 8'h01;
          wr_next    = req_write;
          len_next   = req_length_value;
          act_next   = 1'b0;
          ddone_next = 1'b0;
          term_next  = 1'b0;
          if (!req_hit) begin
            code_next = ctt_pkg::CTT_ACK_NONEX;
          end else if (rty_reg != 16'h0000 || req_miss) begin
            code_next = ctt_pkg::CTT_ACK_NACK;
            if (rty_reg == 16'h0000) begin
              rty_next = retry_reg;
            end
          end else begin
            code_next = ctt_pkg::CTT_ACK_OKAY;
          end
        end
      end
      ctt_pkg::CTT_ST_XFER: begin
        if (dstart) begin
          act_next = 1'b1;
          sub_next = 2'h0;
          oct_next = 5'h00;
        end else if (act_reg && sub_reg == `CTT_OCT_CYCLES) begin
          if (last_oct) begin
            act_next   = 1'b0;
            ddone_next = 1'b1;
          end else begin
            oct_next = oct_reg + 5'h01;
          end
        end
        if (sctrl_valid && act_reg && !in_win) begin
          term_next = 1'b1;
        end
        if (finish) begin
          state_next = ctt_pkg::CTT_ST_IDLE;
        end
      end
      default: state_next = ctt_pkg::CTT_ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ctt_pkg::CTT_ST_IDLE;
      code_reg  <= ctt_pkg::CTT_ACK_OKAY;
      cnt_reg   <= 8'h00;
      wr_reg    <= 1'b0;
      len_reg   <= 5'h00;
      act_reg   <= 1'b0;
      ddone_reg <= 1'b0;
      term_reg  <= 1'b0;
      oct_reg   <= 5'h00;
      sub_reg   <= 2'h0;
      rty_reg   <= 16'h0000;
    end else begin
      state_reg <= state_next;
      code_reg  <= code_next;
      cnt_reg   <= cnt_next;
      wr_reg    <= wr_next;
      len_reg   <= len_next;
      act_reg   <= act_next;
      ddone_reg <= ddone_next;
      term_reg  <= term_next;
      oct_reg   <= oct_next;
      sub_reg   <= sub_next;
      rty_reg   <= rty_next;
    end
  end

  ctt_fifo #(
    .W (DW),
    .D (DEPTH)
  ) u_fifo (
    .clk       (aclk),
    .rst_n     (aresetn),
    .in_valid  (core_rd_valid),
    .in_ready  (core_rd_ready),
    .in_data   (core_rd_data),
    .out_valid (fifo_valid),
    .out_ready (slot & ~wr_reg),
    .out_data  (fifo_data)
  );

  always_comb begin
    ackv_next = (state_reg == ctt_pkg::CTT_ST_XFER) &&
                due(cnt_reg, ack_dly);
    ackc_next = ackv_next ? code_reg : 2'h0;
    rdv_next  = slot & ~wr_reg & fifo_valid;
    rdd_next  = rdv_next ? fifo_data : rdd_reg;
    cwv_next  = act_reg & wr_reg & sub_reg == 2'h0 & wr_in_valid;
    cwd_next  = cwv_next ? wr_in_data : cwd_reg;
    colv_next = 1'b0;
    cola_next = cola_reg;
    done_next = finish;
    if (accept) begin
      colv_next = 1'b1;
      cola_next = req_column;
    end else if (saddr_valid && state_reg == ctt_pkg::CTT_ST_XFER &&
                 code_reg == ctt_pkg::CTT_ACK_OKAY) begin
      colv_next = 1'b1;
      cola_next = serial_column_address;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ackv_reg <= 1'b0;
      ackc_reg <= 2'h0;
      rdv_reg  <= 1'b0;
      rdd_reg  <= '0;
      cwv_reg  <= 1'b0;
      cwd_reg  <= '0;
      colv_reg <= 1'b0;
      cola_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      ackv_reg <= ackv_next;
      ackc_reg <= ackc_next;
      rdv_reg  <= rdv_next;
      rdd_reg  <= rdd_next;
      cwv_reg  <= cwv_next;
      cwd_reg  <= cwd_next;
      colv_reg <= colv_next;
      cola_reg <= cola_next;
      done_reg <= done_next;
    end
  end

  assign ack_valid     = ackv_reg;
  assign ack_code      = ackc_reg;
  assign rd_valid      = rdv_reg;
  assign rd_data       = rdd_reg;
  assign core_wr_valid = cwv_reg;
  assign core_wr_data  = cwd_reg;
  assign col_valid     = colv_reg;
  assign col_addr      = cola_reg;
  assign txn_done      = done_reg;

  sequence s_quiet3;
    !rdv_reg [*3];
  endsequence

  a_ack_delay: assert property (@(posedge aclk) disable iff (!aresetn)
    ackv_reg |-> cnt_reg == {3'h0, ack_dly})
    else $error("acknowledge not at ack delay");
  a_rd_start: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(act_reg) && !wr_reg |-> cnt_reg == {3'h0, rd_dly})
    else $error("read data not at read data delay");
  a_rd_gap: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(act_reg) && !wr_reg |->
      cnt_reg - {3'h0, ack_dly} == {4'h0, dly_reg[`CTT_DLY_GAP_LSB +: 4]})
    else $error("read gap after acknowledge wrong");
  a_wr_start: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(act_reg) && wr_reg |-> cnt_reg == {3'h0, wr_dly})
    else $error("write data window not at write delay");
  a_okay_end: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(done_reg) && code_reg == ctt_pkg::CTT_ACK_OKAY |->
      $past(ddone_reg) && $past(win_over))
    else $error("okay transaction ended early");
  a_nack_nodata: assert property (@(posedge aclk) disable iff (!aresetn)
    code_reg != ctt_pkg::CTT_ACK_OKAY |-> !act_reg && !rdv_next)
    else $error("data moved without okay");
  a_oct_spacing: assert property (@(posedge aclk) disable iff (!aresetn)
    rdv_reg |=> s_quiet3)
    else $error("octbytes closer than four cycles");
  a_len_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    act_reg |-> oct_reg <= len_reg)
    else $error("more octbytes than length value plus one");
  a_term_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    term_reg && act_reg && sub_reg == `CTT_OCT_CYCLES |=> !act_reg ##1 !act_reg)
    else $error("data continued after termination");
  a_retry_nack: assert property (@(posedge aclk) disable iff (!aresetn)
    accept && req_hit && rty_reg != 16'h0000 |=>
      code_reg == ctt_pkg::CTT_ACK_NACK)
    else $error("request accepted during retry interval");
endmodule
`default_nettype wire

//--- verilog/ctt_defines.svh
// Offsets, field positions, reset values and timing counts
`ifndef CTT_DEFINES_SVH
`define CTT_DEFINES_SVH
`define CTT_OFF_CTRL       8'h00
`define CTT_OFF_DELAY      8'h04
`define CTT_OFF_RETRY      8'h08
`define CTT_OFF_STATUS     8'h0C
`define CTT_OFF_COUNT      8'h10
`define CTT_CTRL_EN        0
`define CTT_DLY_ACK_LSB    0
`define CTT_DLY_WIN_LSB    4
`define CTT_DLY_GAP_LSB    8
`define CTT_DLY_WR_LSB     12
`define CTT_ST_BUSY        3
`define CTT_ST_CODE_LSB    4
`define CTT_RST_CTRL       1'h1
`define CTT_RST_DELAY      16'h6224
`define CTT_RST_RETRY      16'h0010
`define CTT_OCT_CYCLES     2'h3
`define CTT_CNT_MAX        8'hFF
`define CTT_RESP_OKAY      2'h0
`define CTT_RESP_SLVERR    2'h2
`endif

//--- verilog/ctt_pkg.sv
// Types shared by the transaction timing engine
package ctt_pkg;
  typedef enum logic [1:0] {
    CTT_ST_IDLE = 2'b00,
    CTT_ST_XFER = 2'b01
  } ctt_state_t;
  typedef enum logic [1:0] {
    CTT_ACK_OKAY  = 2'b00,
    CTT_ACK_NACK  = 2'b01,
    CTT_ACK_NONEX = 2'b10
  } ctt_ack_t;
endpackage

//--- verilog/ctt_fifo.sv
// Read data FIFO with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module ctt_fifo #(
  parameter int W = 64,
  parameter int D = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_reg [D];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]   n_reg, n_next;
  logic [W-1:0]  out_reg, out_next;
  logic          push, pop;

  assign in_ready  = n_reg != D[AW:0];
  assign out_valid = n_reg != '0;
  assign out_data  = out_reg;
  assign push      = in_valid & in_ready;
  assign pop       = out_ready & out_valid;

  always_comb begin
    wp_next = push ? wp_reg + 1'b1 : wp_reg;
    rp_next = pop ? rp_reg + 1'b1 : rp_reg;
    n_next  = n_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    out_next = mem_reg[rp_next];
    if (push && (n_reg == '0 || (pop && n_reg == 1))) begin
      out_next = in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data;
    end
    if (!rst_n) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      n_reg   <= '0;
      out_reg <= '0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      n_reg   <= n_next;
      out_reg <= out_next;
    end
  end
endmodule
`default_nettype wire

//--- verif/ctt_initiator.sv
// Initiator model framing requests, write data and serial packets
`timescale 1ns/100ps
`default_nettype none
module ctt_initiator #(
  parameter int serial_read_offset    = 2,
  parameter int serial_write_offset   = 2,
  parameter int post_memory_write_gap = 4
) (
  input  wire logic   aclk,
  output logic        req_valid,
  output logic        req_write,
  output logic        req_hit,
  output logic        req_miss,
  output logic [4:0]  req_length_value,
  output logic [7:0]  req_column,
  output logic        saddr_valid,
  output logic [7:0]  serial_column_address,
  output logic        sctrl_valid,
  output logic        wr_in_valid,
  output logic [63:0] wr_in_data
);
  initial begin
    {req_valid, req_write, req_hit, req_miss, req_length_value} = '0;
    {req_column, saddr_valid, serial_column_address} = '0;
    {sctrl_valid, wr_in_valid, wr_in_data} = '0;
  end
  // One transaction; tm is the last octbyte index, or -1 for full length
  task automatic txn(input logic w, h, m, input logic [4:0] len,
                     input logic [7:0] col, input int ds, tm,
                     input logic [31:0] b);
    int off, n, k, i;
    off = w ? serial_write_offset : serial_read_offset;
    n = (tm >= 0) ? tm : int'(len);
    @(posedge aclk);
    req_valid        <= 1'b1;
    req_write        <= w;
    req_hit          <= h;
    req_miss         <= m;
    req_length_value <= len;
    req_column       <= col;
    for (int c = 0; c < ds + 4 * n + 6; c++) begin
      @(posedge aclk);
      k = c + 1 - ds;
      i = (k + off) / 4;
      req_valid <= 1'b0;
      wr_in_valid <= w && k >= 0 && k < 4 * n + 4;
      // Released data toggles every cycle
      wr_in_data <= (w && k >= 0 && k < 4 * n + 4) ?
                    {~b, b} ^ 64'(k / 4) : ~wr_in_data;
      saddr_valid <= k + off >= 4 && (k + off) % 4 == 0 && i <= n;
      serial_column_address <= b[7:0] ^ 8'(i);
      sctrl_valid <= tm >= 0 && k == 4 * tm + 4 - off;
    end
    if (w) repeat (post_memory_write_gap) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the transaction timing engine
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic        crv = 1'b0, awr, wr, bv, arr, rv, crr, cwv;
  logic        ack_valid, rd_valid, col_valid, txn_done;
  logic        rqv, rqw, rqh, rqm, sav, scv, wiv;
  logic [7:0]  awa = 8'h00, ara = 8'h00, rc, sca, col_addr;
  logic [31:0] wda = 32'h0, rdt, fb;
  logic [1:0]  br, rr, ack_code, a_k;
  logic [4:0]  rlv;
  logic [63:0] crd = 64'h0, rd_data, cwd, wid;
  logic [63:0] r_q[$], w_q[$];
  logic [7:0]  c_q[$];
  logic [7:0]  ra[4] = '{8'h00, 8'h04, 8'h08, 8'h10};
  logic [31:0] rv_e[4] = '{32'h1, 32'h6224, 32'h10, 32'h0};
  int          err_total = 0, checks = 0, txns = 0, avail = 0;
  int          dak = 4, dwn = 2, dgp = 2, dwd = 6, a_c, r_c, w_c, d_c, d_n;
  always #12.5 aclk = ~aclk;
  ctt_timing dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wda), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .req_valid(rqv), .req_write(rqw), .req_hit(rqh), .req_miss(rqm),
    .req_length_value(rlv), .req_column(rc), .saddr_valid(sav),
    .serial_column_address(sca), .sctrl_valid(scv), .wr_in_valid(wiv),
    .wr_in_data(wid), .ack_valid(ack_valid), .ack_code(ack_code),
    .rd_valid(rd_valid), .rd_data(rd_data), .core_rd_valid(crv),
    .core_rd_ready(crr), .core_rd_data(crd), .core_wr_valid(cwv),
    .core_wr_data(cwd), .col_valid(col_valid), .col_addr(col_addr),
    .txn_done(txn_done)
  );
  ctt_initiator u_init (
    .aclk(aclk), .req_valid(rqv), .req_write(rqw), .req_hit(rqh),
    .req_miss(rqm), .req_length_value(rlv), .req_column(rc),
    .saddr_valid(sav), .serial_column_address(sca), .sctrl_valid(scv),
    .wr_in_valid(wiv), .wr_in_data(wid)
  );
  task automatic conclude;
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  function automatic logic [63:0] rdat(logic [31:0] b, int i);
    return {b, ~b} ^ 64'(i);
  endfunction
  function automatic int edone(int dend);
    return ((dak + dwn > dend) ? dak + dwn : dend) + 1;
  endfunction
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    @(posedge aclk);
    awa <= a;
    wda <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    forever begin
      @(posedge aclk);
      if (bv === 1'b1) begin
        r = br;
        bre <= 1'b0;
        return;
      end
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    forever begin
      @(posedge aclk);
      if (rv === 1'b1) begin
        d = rdt;
        r = rr;
        rre <= 1'b0;
        return;
      end
      if (arr === 1'b1) arv <= 1'b0;
    end
  endtask
  task automatic fill(input int n, output int got);
    int idle;
    got = 0;
    idle = 0;
    fb = $urandom;
    @(posedge aclk);
    crv <= 1'b1;
    crd <= rdat(fb, 0);
    while (got < n && idle < 6) begin
      @(posedge aclk);
      if (crr === 1'b1) begin
        got++;
        crd <= rdat(fb, got);
      end else idle++;
    end
    crv <= 1'b0;
    avail += got;
  endtask
  task automatic watch(input int lim);
    {a_c, r_c, w_c, d_c, d_n} = {-32'sd1, -32'sd1, -32'sd1, -32'sd1, 32'sd0};
    r_q.delete();
    w_q.delete();
    c_q.delete();
    repeat (2) @(posedge aclk);
    for (int c = 1; c <= lim; c++) begin
      @(posedge aclk);
      if (ack_valid === 1'b1 && a_c < 0) {a_c, a_k} = {c, ack_code};
      if (rd_valid === 1'b1) r_q.push_back(rd_data);
      if (rd_valid === 1'b1 && r_c < 0) r_c = c;
      if (cwv === 1'b1) w_q.push_back(cwd);
      if (cwv === 1'b1 && w_c < 0) w_c = c;
      if (col_valid === 1'b1) c_q.push_back(col_addr);
      if (txn_done === 1'b1 && d_c < 0) d_c = c;
      if (txn_done === 1'b1) d_n++;
    end
  endtask
  task automatic run(input logic w, h, m, input int len, tm, nf,
                     input logic [1:0] ec);
    logic [31:0] b;
    logic [7:0]  col;
    int n, ds, got, ne;
    n = (tm >= 0) ? tm : len;
    ds = w ? dwd : dak + dgp;
    col = 8'($urandom);
    if (nf != 0) fill(nf < 0 ? n + 1 : nf, got);
    b = w ? $urandom : fb;
    fork
      u_init.txn(w, h, m, 5'(len), col, ds, tm, b);
      watch(60);
    join
    ne = (ec === 2'h0) ? n + 1 : 0;
    if (!w && ne > avail) ne = avail;
    if (!w) avail -= ne;
    if (ec === 2'h3) begin
      chk("ack_cycle", -1, a_c);
      chk("done_n", 0, d_n);
    end else begin
      txns++;
      chk("ack_cycle", dak, a_c);
      chk("ack_code", ec, a_k);
      chk("done_cycle", edone(w || ec == 0 ? ds + 4 * n + 4 : 0), d_c);
      chk("done_n", 1, d_n);
      chk("rd_count", w ? 0 : ne, r_q.size());
      chk("wr_count", w ? ne : 0, w_q.size());
      if (ne > 0) chk("data_start", w ? ds + 1 : ds, w ? w_c : r_c);
      foreach (r_q[i]) chk("rd_data", rdat(b, i), r_q[i]);
      foreach (w_q[i]) chk("wr_data", rdat(~b, i), w_q[i]);
      chk("col_count", ec === 2'h0 ? n + 1 : 1, c_q.size());
      foreach (c_q[i]) chk("col", i == 0 ? col : b[7:0] ^ 8'(i), c_q[i]);
    end
  endtask
  initial begin
    #(25 * 20000);
    err_total++;
    conclude;
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic        w;
    int          s, got, len, tm;
    s = $urandom(32'hCAD7347A);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ra[i]) begin
      axr(ra[i], d, r);
      chk("reg_reset", rv_e[i], d);
    end
    axw(8'h10, 32'hFFFF, r);
    chk("count_wr_resp", 0, r);
    axr(8'h10, d, r);
    chk("count_ro", 0, d);
    axr(8'h20, d, r);
    chk("unmapped", 64'h2, {d, r});
    axw(8'h00, 32'h0, r);
    run(0, 1, 0, 0, -1, 0, 2'h3);
    axw(8'h00, 32'h1, r);
    run(0, 1, 0, 0, -1, -1, 2'h0);
    run(1, 1, 0, 1, -1, 0, 2'h0);
    run(0, 1, 0, 2, -1, -1, 2'h0);
    run(0, 0, 0, 1, -1, 0, 2'h2);
    run(1, 0, 0, 0, -1, 0, 2'h2);
    axw(8'h08, 32'h100, r);
    run(1, 1, 1, 1, -1, 0, 2'h1);
    run(0, 1, 0, 0, -1, 0, 2'h1);
    axr(8'h0C, d, r);
    chk("status", 32'h18, d);
    repeat (300) @(posedge aclk);
    run(0, 1, 0, 0, -1, -1, 2'h0);
    fill(10, got);
    chk("fifo_fill", 8, got);
    run(0, 1, 0, 7, -1, 0, 2'h0);
    run(0, 1, 0, 0, -1, 0, 2'h0);
    run(0, 1, 0, 5, 2, -1, 2'h0);
    run(1, 1, 0, 4, 1, 0, 2'h0);
    dak = 2 + $urandom % 4;
    dgp = 2 + $urandom % 3;
    dwd = dak + $urandom % 4;
    axw(8'h04, 32'(dwd << 12 | dgp << 8 | dwn << 4 | dak), r);
    axr(8'h04, d, r);
    chk("delay", 32'(dwd << 12 | dgp << 8 | dwn << 4 | dak), d);
    for (int i = 0; i < 8; i++) begin
      w = 1'($urandom);
      len = $urandom % 4;
      tm = ($urandom % 2) ? -1 : int'($urandom % (len + 1));
      run(w, 1'b1, 1'b0, len, tm, w ? 0 : -1, 2'h0);
    end
    axr(8'h10, d, r);
    chk("done_count", txns, d);
    conclude;
  end
endmodule
`default_nettype wire
